/* design/aoc_pkg.sv */
// Shared constants and types for the analog output channel control block.
// Assumes a single 250 MHz system clock with a synchronous active-high reset.
`default_nettype none

package aoc_pkg;
  // Data path width in bits
  localparam int AOC_DW = 16;
  // Clock and time base
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_PERIOD_NS = 1000000;
  localparam int CYCLES_PER_MS_DFLT = MS_PERIOD_NS / CLK_PERIOD_NS;
  // Fault state durations in milliseconds
  localparam int MS_CNT_W = 14;
  localparam logic [MS_CNT_W-1:0] DUR_1S_MS = 14'h03E8;
  localparam logic [MS_CNT_W-1:0] DUR_2S_MS = 14'h07D0;
  localparam logic [MS_CNT_W-1:0] DUR_5S_MS = 14'h1388;
  localparam logic [MS_CNT_W-1:0] DUR_10S_MS = 14'h2710;
  // Fault duration selector codes; unknown codes behave as forever
  localparam logic [2:0] DUR_FOREVER = 3'h0;
  localparam logic [2:0] DUR_1S = 3'h1;
  localparam logic [2:0] DUR_2S = 3'h2;
  localparam logic [2:0] DUR_5S = 3'h3;
  localparam logic [2:0] DUR_10S = 3'h4;
  // Output type and range codes
  localparam logic TYPE_CURRENT = 1'h0;
  localparam logic TYPE_VOLTAGE = 1'h1;
  localparam logic [2:0] RANGE_0_20MA = 3'h0;
  localparam logic [2:0] RANGE_4_20MA = 3'h1;
  localparam logic [2:0] RANGE_PM10V = 3'h2;
  localparam logic [2:0] RANGE_0_5V = 3'h3;
  localparam logic [2:0] RANGE_0_10V = 3'h4;
  // Full-scale spans in counts and the 0.1 percent match window
  localparam int FS_SPAN_UNI = 30000;
  localparam int FS_SPAN_BI = 60000;
  localparam int MATCH_PER_MILLE = 1;
  localparam logic [AOC_DW:0] TOL_UNI = 17'((FS_SPAN_UNI * MATCH_PER_MILLE) / 1000);
  localparam logic [AOC_DW:0] TOL_BI = 17'((FS_SPAN_BI * MATCH_PER_MILLE) / 1000);
  // Fault mode codes
  localparam logic FAULT_MODE_VALUE = 1'h0;
  localparam logic FAULT_MODE_HOLD = 1'h1;
  // Alarm bit positions
  localparam int ALM_LOW = 0;
  localparam int ALM_HIGH = 1;
  // Reset values
  localparam logic [AOC_DW-1:0] OUT_RST = 16'h0000;
  // Connection fault handling states
  typedef enum logic [1:0] {
    FST_NORMAL, FST_FAULT_VALUE, FST_FINAL, FST_HOLD_LAST
  } aoc_fault_state_type;
endpackage

`default_nettype wire

/* design/aoc_chan_if.sv */
// Internal carrier between the channel top and its clamp and timer units.
// Assumes all members live in the system clock domain.
`default_nettype none

interface aoc_chan_if #(parameter int DW = 16, parameter int MW = 14);
  // Clamp group
  logic signed [DW-1:0] cmd;
  logic signed [DW-1:0] clamp_hi;
  logic signed [DW-1:0] clamp_lo;
  logic [1:0] alarm_en;
  logic [1:0] alarm_latch;
  logic cfg_load;
  logic alarm_clear;
  logic signed [DW-1:0] clamped;
  logic [1:0] alarm_flag;
  // Fault timer group
  logic timer_start;
  logic timer_run;
  logic [2:0] timer_dur;
  logic timer_expired;

  modport clamp_mp (input cmd, clamp_hi, clamp_lo, alarm_en, alarm_latch, cfg_load,
    alarm_clear, output clamped, alarm_flag);
  modport timer_mp (input timer_start, timer_run, timer_dur, output timer_expired);
  modport user_mp (output cmd, clamp_hi, clamp_lo, alarm_en, alarm_latch, cfg_load,
    alarm_clear, timer_start, timer_run, timer_dur, input clamped, alarm_flag,
    timer_expired);
endinterface

`default_nettype wire

/* design/aoc_fault_timer.sv */
// Millisecond-based fault state duration timer.
// Assumes start is a one-cycle pulse and run stays high while the fault lasts.
`default_nettype none

module aoc_fault_timer
  import aoc_pkg::*;
#(
  parameter int CYCLES_PER_MS = CYCLES_PER_MS_DFLT
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  aoc_chan_if.timer_mp tmr
);
  localparam int PW = $clog2(CYCLES_PER_MS + 1);
  logic [PW-1:0] pre_r;
  logic [MS_CNT_W-1:0] ms_r;
  logic [MS_CNT_W-1:0] target;
  logic ms_tick;

  assign ms_tick = (pre_r == PW'(CYCLES_PER_MS - 1));

  // Prescaler restarts on each new fault so every fault gets a full period
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || tmr.timer_start || !tmr.timer_run) begin
      pre_r <= '0;
    end else begin
      pre_r <= ms_tick ? '0 : pre_r + 1'b1;
    end
  end

  // Millisecond count saturates at expiry
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || tmr.timer_start) begin
      ms_r <= '0;
    end else if (tmr.timer_run && ms_tick && !tmr.timer_expired) begin
      ms_r <= ms_r + 1'b1;
    end
  end

  // Zero target means the fault value stands forever
  always_comb begin
    case (tmr.timer_dur)
      DUR_1S: target = DUR_1S_MS;
      DUR_2S: target = DUR_2S_MS;
      DUR_5S: target = DUR_5S_MS;
      DUR_10S: target = DUR_10S_MS;
      default: target = '0;
    endcase
  end

  assign tmr.timer_expired = (target != '0) && (ms_r >= target);

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  chk_timer_restart: assert property (tmr.timer_start |=> !tmr.timer_expired)
    else $error("fault timer not restarted by new fault");
  chk_timer_forever: assert property (tmr.timer_dur == DUR_FOREVER |-> !tmr.timer_expired)
    else $error("forever duration expired");
endmodule // aoc_fault_timer

`default_nettype wire

/* design/aoc_clamp_alarm.sv */
// Output clamp and low/high clamp alarms with enable and latch per alarm.
// Assumes clamp limits are engineering-unit counts held by the top.
`default_nettype none

module aoc_clamp_alarm
  import aoc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  aoc_chan_if.clamp_mp clp
);
  logic [1:0] viol;
  logic [1:0] en_r;
  logic [1:0] latch_r;
  logic [1:0] latched_r;
  logic [1:0] flag_r;

  assign viol[ALM_LOW] = (clp.cmd < clp.clamp_lo);
  assign viol[ALM_HIGH] = (clp.cmd > clp.clamp_hi);

  // Drive the violated limit instead of the command
  always_comb begin
    if (viol[ALM_HIGH]) begin
      clp.clamped = clp.clamp_hi;
    end else if (viol[ALM_LOW]) begin
      clp.clamped = clp.clamp_lo;
    end else begin
      clp.clamped = clp.cmd;
    end
  end

  // Alarm setup loads only on a configuration strobe; disabled after reset
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      en_r <= 2'h0;
      latch_r <= 2'h0;
    end else if (clp.cfg_load) begin
      en_r <= clp.alarm_en;
      latch_r <= clp.alarm_latch;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_alarm
      // A new violation wins over a clear in the same cycle
      always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
          latched_r[g] <= 1'b0;
        end else if (en_r[g] && latch_r[g] && viol[g]) begin
          latched_r[g] <= 1'b1;
        end else if (clp.alarm_clear || clp.cfg_load) begin
          latched_r[g] <= 1'b0;
        end
      end
      // Flag reports a live or latched violation
      always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
          flag_r[g] <= 1'b0;
        end else begin
          flag_r[g] <= en_r[g] && (viol[g] || latched_r[g]);
        end
      end
    end
  endgenerate

  assign clp.alarm_flag = flag_r;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  chk_clamp_high_limit: assert property (viol[ALM_HIGH] |-> clp.clamped == clp.clamp_hi)
    else $error("high clamp not applied");
  chk_low_alarm_set: assert property (en_r[ALM_LOW] && viol[ALM_LOW] |=> flag_r[ALM_LOW])
    else $error("low clamp alarm not raised");
  chk_alarm_latch_hold: assert property (en_r[ALM_HIGH] && flag_r[ALM_HIGH] && latched_r[ALM_HIGH]
    && !clp.alarm_clear && !clp.cfg_load |=> ##1 flag_r[ALM_HIGH])
    else $error("latched high alarm dropped without clear");
endmodule // aoc_clamp_alarm

`default_nettype wire

/* design/aoc_channel_ctrl.sv */
// Control logic for one analog output channel: range, offset, clamping,
// hold for initialization and connection fault handling.
// Assumes command, connection and mode inputs come from logic on clk_sys_in;
// the field supply status arrives from a pin and is synchronised here.
`default_nettype none

module aoc_channel_ctrl
  import aoc_pkg::*;
#(
  parameter int DW = AOC_DW,
  parameter int CYCLES_PER_MS = CYCLES_PER_MS_DFLT
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic conn_ok_in,
  input wire logic run_mode_in,
  input wire logic field_supply_ok_in,
  input wire logic signed [DW-1:0] cmd_value_in,
  input wire logic signed [DW-1:0] terminal_value_in,
  input wire logic cfg_load_in,
  input wire logic cfg_output_type_in,
  input wire logic [2:0] cfg_range_sel_in,
  input wire logic signed [DW-1:0] cfg_offset_in,
  input wire logic cfg_hold_init_en_in,
  input wire logic cfg_fault_mode_in,
  input wire logic [2:0] cfg_fault_dur_in,
  input wire logic signed [DW-1:0] cfg_fault_value_in,
  input wire logic signed [DW-1:0] cfg_final_value_in,
  input wire logic signed [DW-1:0] cfg_clamp_high_in,
  input wire logic signed [DW-1:0] cfg_clamp_low_in,
  input wire logic [1:0] cfg_alarm_en_in,
  input wire logic [1:0] cfg_alarm_latch_in,
  input wire logic alarm_clear_in,
  output logic signed [DW-1:0] dac_value_out,
  output logic [2:0] dac_range_out,
  output logic range_error_out,
  output logic signed [DW-1:0] echo_value_out,
  output logic channel_holding_flag_out,
  output logic low_clamp_alarm_flag_out,
  output logic high_clamp_alarm_flag_out,
  output logic fault_active_out
);
  aoc_chan_if #(.DW(DW), .MW(MS_CNT_W)) ch_if ();

  aoc_fault_state_type fault_state_r, fault_state_nxt;
  logic fs_meta_r;
  logic fs_sync_r;
  logic fs_prev_r;
  logic conn_prev_r;
  logic run_prev_r;
  logic ever_conn_r;
  logic hold_r;
  logic hold_trigger;
  logic hold_active;
  logic in_tol;
  logic range_legal;
  logic [2:0] range_nxt;
  logic [2:0] range_r;
  logic range_err_r;
  logic signed [DW-1:0] out_r;
  logic signed [DW-1:0] echo_r;
  logic signed [DW-1:0] normal_value;
  logic signed [DW:0] offs_sum;
  logic signed [DW:0] match_diff;
  logic [DW:0] match_abs;
  logic [DW:0] tol;

  // Clamp and alarm unit; limits pass straight through, never rescaled
  assign ch_if.cmd = cmd_value_in;
  assign ch_if.clamp_hi = cfg_clamp_high_in;
  assign ch_if.clamp_lo = cfg_clamp_low_in;
  assign ch_if.alarm_en = cfg_alarm_en_in;
  assign ch_if.alarm_latch = cfg_alarm_latch_in;
  assign ch_if.cfg_load = cfg_load_in;
  assign ch_if.alarm_clear = alarm_clear_in;

  aoc_clamp_alarm u_clamp (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .clp(ch_if.clamp_mp)
  );

  // Fault duration timer, started on entry to the fault value state
  assign ch_if.timer_start = (fault_state_r != FST_FAULT_VALUE)
    && (fault_state_nxt == FST_FAULT_VALUE);
  assign ch_if.timer_run = (fault_state_r == FST_FAULT_VALUE);
  assign ch_if.timer_dur = cfg_fault_dur_in;

  aoc_fault_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_timer (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .tmr(ch_if.timer_mp)
  );

  // Field supply status comes from a pin: two flops before any use
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      fs_meta_r <= 1'b1;
      fs_sync_r <= 1'b1;
      fs_prev_r <= 1'b1;
    end else begin
      fs_meta_r <= field_supply_ok_in;
      fs_sync_r <= fs_meta_r;
      fs_prev_r <= fs_sync_r;
    end
  end

  // Edge history; connection is seen as down from reset so the first link counts
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      conn_prev_r <= 1'b0;
      run_prev_r <= 1'b0;
      ever_conn_r <= 1'b0;
    end else begin
      conn_prev_r <= conn_ok_in;
      run_prev_r <= run_mode_in;
      ever_conn_r <= ever_conn_r || conn_ok_in;
    end
  end

  // Range check against the output type; illegal picks fall back to a safe range
  always_comb begin
    if (cfg_output_type_in == TYPE_CURRENT) begin
      range_legal = (cfg_range_sel_in == RANGE_0_20MA)
        || (cfg_range_sel_in == RANGE_4_20MA);
      range_nxt = range_legal ? cfg_range_sel_in : RANGE_0_20MA;
    end else begin
      range_legal = (cfg_range_sel_in == RANGE_PM10V) || (cfg_range_sel_in == RANGE_0_5V)
        || (cfg_range_sel_in == RANGE_0_10V);
      range_nxt = range_legal ? cfg_range_sel_in : RANGE_PM10V;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      range_r <= RANGE_0_20MA;
      range_err_r <= 1'b0;
    end else begin
      range_r <= range_nxt;
      range_err_r <= !range_legal;
    end
  end

  // Offset added after clamping, saturated so a wrap cannot flip the output
  assign offs_sum = {ch_if.clamped[DW-1], ch_if.clamped}
    + {cfg_offset_in[DW-1], cfg_offset_in};
  always_comb begin
    if (offs_sum[DW] != offs_sum[DW-1]) begin
      normal_value = offs_sum[DW] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
    end else begin
      normal_value = offs_sum[DW-1:0];
    end
  end

  // Match window is 0.1 percent of the active range span
  assign tol = (range_r == RANGE_PM10V) ? TOL_BI : TOL_UNI;
  assign match_diff = {normal_value[DW-1], normal_value}
    - {terminal_value_in[DW-1], terminal_value_in};
  assign match_abs = match_diff[DW] ? (DW+1)'(-match_diff) : match_diff;
  assign in_tol = (match_abs <= tol);

  // Hold triggers: link up (first or after fault), program to run, supply loss
  assign hold_trigger = cfg_hold_init_en_in && ((conn_ok_in && !conn_prev_r)
    || (run_mode_in && !run_prev_r) || (fs_prev_r && !fs_sync_r));
  assign hold_active = hold_r || hold_trigger;

  // Hold flag: a new trigger wins over a match in the same cycle
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      hold_r <= 1'b0;
    end else if (hold_trigger) begin
      hold_r <= 1'b1;
    end else if (!cfg_hold_init_en_in) begin
      hold_r <= 1'b0;
    end else if (hold_r && conn_ok_in && fs_sync_r && in_tol) begin
      hold_r <= 1'b0;
    end
  end

  // Connection fault handling; no fault before the first connection
  always_comb begin
    fault_state_nxt = fault_state_r;
    case (fault_state_r)
      FST_NORMAL: begin
        if (!conn_ok_in && ever_conn_r) begin
          fault_state_nxt = (cfg_fault_mode_in == FAULT_MODE_HOLD)
            ? FST_HOLD_LAST : FST_FAULT_VALUE;
        end
      end
      FST_FAULT_VALUE: begin
        if (conn_ok_in) begin
          fault_state_nxt = FST_NORMAL;
        end else if (ch_if.timer_expired) begin
          fault_state_nxt = FST_FINAL;
        end
      end
      FST_FINAL: begin
        if (conn_ok_in) begin
          fault_state_nxt = FST_NORMAL;
        end
      end
      FST_HOLD_LAST: begin
        if (conn_ok_in) begin
          fault_state_nxt = FST_NORMAL;
        end
      end
      default: fault_state_nxt = FST_NORMAL;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      fault_state_r <= FST_NORMAL;
    end else begin
      fault_state_r <= fault_state_nxt;
    end
  end

  // Converter setpoint; fault handling outranks the initialization hold.
  // A dropped link carries no valid command, so the cycle it falls keeps the output
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      out_r <= OUT_RST;
    end else if (fault_state_r == FST_FAULT_VALUE) begin
      out_r <= cfg_fault_value_in;
    end else if (fault_state_r == FST_FINAL) begin
      out_r <= cfg_final_value_in;
    end else if (fault_state_r == FST_HOLD_LAST || hold_active || !conn_ok_in) begin
      out_r <= out_r;
    end else begin
      out_r <= normal_value;
    end
  end

  // Echo tracks the setpoint but reads zero while field supply is missing
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      echo_r <= OUT_RST;
    end else begin
      echo_r <= fs_sync_r ? out_r : OUT_RST;
    end
  end

  assign dac_value_out = out_r;
  assign dac_range_out = range_r;
  assign range_error_out = range_err_r;
  assign echo_value_out = echo_r;
  assign channel_holding_flag_out = hold_r;
  assign low_clamp_alarm_flag_out = ch_if.alarm_flag[ALM_LOW];
  assign high_clamp_alarm_flag_out = ch_if.alarm_flag[ALM_HIGH];
  assign fault_active_out = (fault_state_r != FST_NORMAL);

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  chk_range_current_only: assert property (cfg_output_type_in == TYPE_CURRENT
    |=> dac_range_out == RANGE_0_20MA || dac_range_out == RANGE_4_20MA)
    else $error("current type drove a voltage range");
  chk_hold_keeps_out: assert property (hold_r && fault_state_r == FST_NORMAL
    |=> dac_value_out == $past(dac_value_out))
    else $error("held output changed");
  chk_hold_release: assert property (hold_r && !hold_trigger && cfg_hold_init_en_in
    && conn_ok_in && fs_sync_r && in_tol |=> !channel_holding_flag_out)
    else $error("hold not released on match");
  chk_hold_on_connect: assert property (cfg_hold_init_en_in && conn_ok_in && !conn_prev_r
    |=> channel_holding_flag_out)
    else $error("no hold after connection");
  chk_echo_supply_zero: assert property (!fs_sync_r |=> echo_value_out == OUT_RST)
    else $error("echo not zero without field supply");
  chk_fault_mode_hold: assert property (fault_state_r == FST_NORMAL && ever_conn_r
    && !conn_ok_in && cfg_fault_mode_in == FAULT_MODE_HOLD
    |=> fault_state_r == FST_HOLD_LAST ##1 $stable(dac_value_out))
    else $error("hold-last fault mode not kept");
  chk_fault_value_out: assert property (fault_state_r == FST_FAULT_VALUE
    |=> dac_value_out == $past(cfg_fault_value_in))
    else $error("fault value not driven");
  chk_final_after_expiry: assert property (fault_state_r == FST_FAULT_VALUE && !conn_ok_in
    && ch_if.timer_expired |=> fault_state_r == FST_FINAL ##1
    dac_value_out == $past(cfg_final_value_in))
    else $error("final fault value not reached");
  chk_reconnect_normal: assert property (fault_state_r != FST_NORMAL && conn_ok_in
    |=> !fault_active_out)
    else $error("fault kept after reconnection");

  cov_fault_to_final: cover property (fault_state_r == FST_FAULT_VALUE
    ##1 fault_state_r == FST_FINAL);
  cov_hold_release: cover property (hold_r ##1 !hold_r);
  cov_high_alarm: cover property (high_clamp_alarm_flag_out);
  cov_reconnect: cover property (fault_state_r == FST_FINAL ##1 fault_state_r == FST_NORMAL);
endmodule // aoc_channel_ctrl

`default_nettype wire

/* dv/aoc_owner_model.sv */
// Owner controller stand-in: publishes connection, mode and command each cycle.
// Assumes the bench requests changes; outputs move on the next clock edge.
`default_nettype none

module aoc_owner_model
  import aoc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic link_in,
  input wire logic run_in,
  input wire logic signed [AOC_DW-1:0] value_in,
  output logic conn_ok_out,
  output logic run_mode_out,
  output logic signed [AOC_DW-1:0] cmd_value_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Cyclic update; a broken link carries no data, so the bus toggles
  // rather than parking on the last good value
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      conn_ok_out <= 1'b0;
      run_mode_out <= 1'b0;
      cmd_value_out <= 16'h0000;
    end else begin
      conn_ok_out <= link_in;
      run_mode_out <= run_in;
      cmd_value_out <= link_in ? value_in : ~cmd_value_out;
    end
  end
endmodule // aoc_owner_model

`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for one analog output channel beside an owner model.
// Assumes a shortened millisecond tick so the fault durations fit the run.
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end

module tb
  import aoc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic signed [AOC_DW-1:0] FV = 16'h0123;
  localparam logic signed [AOC_DW-1:0] FIN = 16'h0456;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic link = 1'b0, run = 1'b0, fok = 1'b1, load = 1'b0, clr = 1'b0, vtype = 1'b1;
  logic hold_en = 1'b0, fmode = 1'b0, conn, runm, rerr, hold, lo_f, hi_f, fact;
  logic [2:0] rsel = 3'h2, drange, dur = 3'h1;
  logic [1:0] aen = 2'h0, alat = 2'h0;
  logic signed [AOC_DW-1:0] val = 16'h0000, term = 16'h0000, off = 16'h0000;
  logic signed [AOC_DW-1:0] cmdv, dac, echo;
  int err_count = 0, samples_checked = 0, cycles = 0, n, v;

  aoc_owner_model owner (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link_in(link),
    .run_in(run), .value_in(val), .conn_ok_out(conn), .run_mode_out(runm),
    .cmd_value_out(cmdv));
  // Fault values and clamp limits stay fixed; one second is 4000 cycles here
  aoc_channel_ctrl #(.CYCLES_PER_MS(4)) dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .conn_ok_in(conn), .run_mode_in(runm), .field_supply_ok_in(fok), .cmd_value_in(cmdv),
    .terminal_value_in(term), .cfg_load_in(load), .cfg_output_type_in(vtype),
    .cfg_range_sel_in(rsel), .cfg_offset_in(off), .cfg_hold_init_en_in(hold_en),
    .cfg_fault_mode_in(fmode), .cfg_fault_dur_in(dur), .cfg_fault_value_in(FV),
    .cfg_final_value_in(FIN), .cfg_clamp_high_in(16'h03E8), .cfg_clamp_low_in(16'hFC18),
    .cfg_alarm_en_in(aen), .cfg_alarm_latch_in(alat), .alarm_clear_in(clr),
    .dac_value_out(dac), .dac_range_out(drange), .range_error_out(rerr),
    .echo_value_out(echo), .channel_holding_flag_out(hold),
    .low_clamp_alarm_flag_out(lo_f), .high_clamp_alarm_flag_out(hi_f),
    .fault_active_out(fact));

  initial forever #2 clk_sys_in = ~clk_sys_in;

  // Clamp to +-1000 counts first, offset after, as the datapath does
  function automatic logic signed [AOC_DW-1:0] exp_out(input int c);
    int k;
    k = (c > 1000) ? 1000 : ((c < -1000) ? -1000 : c);
    return AOC_DW'(k + off);
  endfunction
  // Error flag then effective range; illegal picks fall back per type
  function automatic logic [3:0] exp_rng(input logic t, input logic [2:0] r);
    logic e;
    e = t ? (r < 3'h2 || r > 3'h4) : (r > 3'h1);
    return {e, e ? (t ? RANGE_PM10V : RANGE_0_20MA) : r};
  endfunction
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys_in);
  endtask
  // Command passes the owner model and the channel: two edges, four for margin
  task automatic put(input int c);
    @(posedge clk_sys_in);
    val <= AOC_DW'(c);
    step(4);
  endtask
  task automatic print_verdict();
    $display("Counts: checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Hang guard: the longest test waits about 8100 cycles
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    void'($urandom(99045));
    step(10);
    rst_in <= 1'b0;
    step(1);
    `CHK({dac, lo_f, hi_f, hold, fact}, 20'h00000)
    link <= 1'b1;
    put(2000);
    `CHK({lo_f, hi_f, dac}, {2'h0, exp_out(2000)})
    $display("test reset_clamp done");
    for (n = 0; n < 20; n++) begin
      off <= AOC_DW'($urandom_range(100)) - 16'h0032;
      v = int'($urandom_range(1800)) - 900;
      put(v);
      `CHK({dac, echo}, {exp_out(v), exp_out(v)})
    end
    $display("test offset done");
    @(posedge clk_sys_in);
    aen <= 2'h3;
    alat <= 2'h3;
    load <= 1'b1;
    @(posedge clk_sys_in);
    load <= 1'b0;
    put(-2000);
    `CHK({lo_f, hi_f, dac}, {2'h2, exp_out(-2000)})
    put(0);
    `CHK(lo_f, 1'b1)
    clr <= 1'b1;
    @(posedge clk_sys_in);
    clr <= 1'b0;
    step(3);
    `CHK(lo_f, 1'b0)
    put(2000);
    `CHK({lo_f, hi_f}, 2'h1)
    $display("test alarms done");
    for (n = 0; n < 16; n++) begin
      vtype <= n[0];
      rsel <= 3'(n >> 1);
      step(3);
      `CHK({rerr, drange}, exp_rng(n[0], 3'(n >> 1)))
    end
    vtype <= 1'b1;
    rsel <= 3'h2;
    $display("test ranges done");
    link <= 1'b0;
    step(4);
    `CHK({fact, dac}, {1'b1, FV})
    n = 0;
    while (dac === FV && n < 5000) begin
      step(1);
      n++;
    end
    `CHK(dac, FIN)
    `CHK(n > 3990 && n < 4010, 1'b1)
    link <= 1'b1;
    put(100);
    `CHK({fact, dac}, {1'b0, exp_out(100)})
    // Forever duration: the fault value must outlast the one-second span
    dur <= DUR_FOREVER;
    link <= 1'b0;
    step(4100);
    `CHK({fact, dac}, {1'b1, FV})
    link <= 1'b1;
    put(100);
    `CHK({fact, dac}, {1'b0, exp_out(100)})
    $display("test fault_value done");
    fmode <= 1'b1;
    link <= 1'b0;
    put(300);
    `CHK({fact, dac}, {1'b1, exp_out(100)})
    link <= 1'b1;
    put(300);
    `CHK(dac, exp_out(300))
    fmode <= 1'b0;
    $display("test hold_last done");
    // Terminal far away, so the hold cannot release by accident
    hold_en <= 1'b1;
    term <= 16'h7000;
    run <= 1'b1;
    put(500);
    `CHK({hold, dac}, {1'b1, exp_out(300)})
    term <= exp_out(500);
    step(4);
    `CHK({hold, dac}, {1'b0, exp_out(500)})
    $display("test hold_init done");
    fok <= 1'b0;
    step(6);
    `CHK({hold, echo}, {1'b1, 16'h0000})
    fok <= 1'b1;
    step(6);
    `CHK(hold, 1'b0)
    $display("test supply_loss done");
    print_verdict();
  end
endmodule // tb

`default_nettype wire
